// File: design/mie_pkg.sv
/*
  Constants for the move-instruction execute block: opcode patterns,
  field positions, widths and reset values.
  Assumes a 12-bit instruction word presented once per instruction cycle.
*/
package mie_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int REG_COUNT = 32;
  localparam int DEST_BIT = 5;
  localparam int COPY_LSB = 6;
  localparam int STORE_LSB = 5;
  localparam int LIT_LSB = 8;
  localparam logic [5:0] COPY_TOP = 6'h08;
  localparam logic [6:0] STORE_TOP = 7'h01;
  localparam logic [3:0] LIT_TOP = 4'hC;
  localparam logic [11:0] IDLE_WORD = 12'h000;
  localparam logic [11:0] PRESCALE_WORD = 12'h002;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    MIE_OP_IDLE,
    MIE_OP_COPY,
    MIE_OP_STORE,
    MIE_OP_LITERAL,
    MIE_OP_PRESCALE,
    MIE_OP_OTHER
  } mie_op_t;
endpackage : mie_pkg

// File: design/mie_rf_if.sv
/*
  Interface carrying the file register read and write ports.
  Assumes the execute core is the master and the register file the target.
*/
`timescale 1ns/1ps
interface mie_rf_if;
  import mie_pkg::*;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  modport core (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport regs (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : mie_rf_if

// File: design/mie_regfile.sv
/*
  32-entry 8-bit file register array with combinational read.
  Assumes one write per clock; read shows contents before that write.
*/
`timescale 1ns/1ps
module mie_regfile
  import mie_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  mie_rf_if.regs rf // Read and write ports
);
  logic [DATA_W-1:0] mem [REG_COUNT];

  assign rf.rd_data = mem[rf.rd_addr];

  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (rst) begin
          mem[i] <= REG_RESET;
        end else if (rf.wr_en && rf.wr_addr == ADDR_W'(i)) begin
          mem[i] <= rf.wr_data;
        end
      end
    end
  endgenerate
endmodule : mie_regfile

// File: design/mie_exec.sv
/*
  Execute stage for the data-movement instruction group: copy file
  register, load literal, store accumulator, idle and prescaler load.
  Assumes one valid instruction word per clock from the fetch path.
*/
`timescale 1ns/1ps
module mie_exec
  import mie_pkg::*;
(
  input wire logic clk, // Core instruction clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic instr_valid, // Instruction word present
  input wire logic [INSTR_W-1:0] instr, // Instruction word
  output logic [DATA_W-1:0] acc, // Accumulator
  output logic null_result_flag, // Zero flag
  output logic [DATA_W-1:0] prescale_cfg, // Prescaler configuration
  output logic done, // Instruction retired pulse
  output logic unhandled // Word outside this group
);
  mie_rf_if rf ();

  // Fields of the word at the input
  logic [INSTR_W-COPY_LSB-1:0] copy_opc;
  logic [INSTR_W-STORE_LSB-1:0] store_opc;
  logic [INSTR_W-LIT_LSB-1:0] lit_opc;
  logic [DATA_W-1:0] lit_value;
  logic [ADDR_W-1:0] faddr;
  logic dest_file;

  // One match per instruction shape
  logic is_idle;
  logic is_prescale;
  logic is_copy;
  logic is_store;
  logic is_literal;

  // Decoded operation
  mie_op_t op;

  // Control for this cycle
  logic acc_from_file;
  logic acc_from_literal;
  logic flag_write;
  logic file_write;
  logic file_from_acc;
  logic prescale_write;
  logic word_foreign;

  // Read data show the contents before this edge's write
  logic [DATA_W-1:0] moved;
  logic moved_is_zero;

  mie_regfile u_regfile (
    .clk(clk),
    .rst(rst),
    .rf(rf)
  );

  // Field extraction
  assign copy_opc = instr[INSTR_W-1:COPY_LSB];
  assign store_opc = instr[INSTR_W-1:STORE_LSB];
  assign lit_opc = instr[INSTR_W-1:LIT_LSB];
  assign lit_value = instr[DATA_W-1:0];
  assign faddr = instr[ADDR_W-1:0];
  assign dest_file = instr[DEST_BIT];

  // Whole-word codes fall inside no other shape
  assign is_idle = (instr == IDLE_WORD);
  assign is_prescale = (instr == PRESCALE_WORD);
  assign is_copy = (copy_opc == COPY_TOP);
  assign is_store = (store_opc == STORE_TOP);
  assign is_literal = (lit_opc == LIT_TOP);

  // Decode; a word without valid counts as idle
  always_comb begin
    if (!instr_valid) begin
      op = MIE_OP_IDLE;
    end else if (is_idle) begin
      op = MIE_OP_IDLE;
    end else if (is_prescale) begin
      op = MIE_OP_PRESCALE;
    end else if (is_copy) begin
      op = MIE_OP_COPY;
    end else if (is_store) begin
      op = MIE_OP_STORE;
    end else if (is_literal) begin
      op = MIE_OP_LITERAL;
    end else begin
      op = MIE_OP_OTHER;
    end
  end

  // Accumulator source
  always_comb begin
    acc_from_file = 1'b0;
    acc_from_literal = 1'b0;
    unique case (op)
      MIE_OP_COPY: begin
        acc_from_file = !dest_file;
      end
      MIE_OP_LITERAL: begin
        acc_from_literal = 1'b1;
      end
      MIE_OP_IDLE, MIE_OP_STORE, MIE_OP_PRESCALE, MIE_OP_OTHER: begin
      end
    endcase
  end

  // File register write control
  always_comb begin
    file_write = 1'b0;
    file_from_acc = 1'b0;
    unique case (op)
      MIE_OP_COPY: begin
        file_write = dest_file;
      end
      MIE_OP_STORE: begin
        file_write = 1'b1;
        file_from_acc = 1'b1;
      end
      MIE_OP_IDLE, MIE_OP_LITERAL, MIE_OP_PRESCALE, MIE_OP_OTHER: begin
      end
    endcase
  end

  // Zero flag control
  always_comb begin
    flag_write = 1'b0;
    unique case (op)
      MIE_OP_COPY: begin
        flag_write = 1'b1;
      end
      MIE_OP_IDLE, MIE_OP_STORE, MIE_OP_LITERAL, MIE_OP_PRESCALE, MIE_OP_OTHER: begin
      end
    endcase
  end

  // Prescaler control
  always_comb begin
    prescale_write = 1'b0;
    unique case (op)
      MIE_OP_PRESCALE: begin
        prescale_write = 1'b1;
      end
      MIE_OP_IDLE, MIE_OP_COPY, MIE_OP_STORE, MIE_OP_LITERAL, MIE_OP_OTHER: begin
      end
    endcase
  end

  // Foreign word detection
  always_comb begin
    word_foreign = 1'b0;
    unique case (op)
      MIE_OP_OTHER: begin
        word_foreign = 1'b1;
      end
      MIE_OP_IDLE, MIE_OP_COPY, MIE_OP_STORE, MIE_OP_LITERAL, MIE_OP_PRESCALE: begin
      end
    endcase
  end

  // Read port follows the address field every cycle
  assign rf.rd_addr = faddr;
  assign moved = rf.rd_data;
  assign moved_is_zero = (moved == ZERO_BYTE);

  // Write port; copy-back returns the value just read
  always_comb begin
    rf.wr_addr = faddr;
    rf.wr_en = file_write;
    if (file_from_acc) begin
      rf.wr_data = acc;
    end else begin
      rf.wr_data = moved;
    end
  end

  // Accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= ACC_RESET;
    end else if (acc_from_file) begin
      acc <= moved;
    end else if (acc_from_literal) begin
      acc <= lit_value;
    end
  end

  // Zero flag, copy only
  always_ff @(posedge clk) begin
    if (rst) begin
      null_result_flag <= 1'b0;
    end else if (flag_write) begin
      null_result_flag <= moved_is_zero;
    end
  end

  // Prescaler configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      prescale_cfg <= PRESCALE_RESET;
    end else if (prescale_write) begin
      prescale_cfg <= acc;
    end
  end

  // Retire pulse for every taken word
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= instr_valid;
    end
  end

  // Pulse for a word outside this group
  always_ff @(posedge clk) begin
    if (rst) begin
      unhandled <= 1'b0;
    end else begin
      unhandled <= word_foreign;
    end
  end
endmodule : mie_exec

// File: testbench/mie_exec_asserts.sv
/* Port checker for mie_exec.
   Assumes a bind onto mie_exec. */
`timescale 1ns/1ps
module mie_exec_asserts
  import mie_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic instr_valid, // Valid
  input wire logic [INSTR_W-1:0] instr, // Word
  input wire logic [DATA_W-1:0] acc, // Acc
  input wire logic null_result_flag, // Zero
  input wire logic [DATA_W-1:0] prescale_cfg, // Prescale
  input wire logic done, // Retired
  input wire logic unhandled // Other
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire lit = instr_valid && instr[11:8] == LIT_TOP;
  wire cpy = instr_valid && instr[11:6] == COPY_TOP;
  wire sto = instr_valid && instr[11:5] == STORE_TOP;
  wire pre = instr_valid && instr == PRESCALE_WORD;
  wire idle_instr = instr_valid && instr == IDLE_WORD;
  a_lit_sets_acc: assert property (lit |=> acc == $past(instr[7:0]) && $stable(null_result_flag))
    else $error("lit");
  a_copy_to_acc: assert property (cpy && !instr[5] |=> null_result_flag == (acc == ZERO_BYTE))
    else $error("copy");
  a_copy_keeps_acc: assert property (cpy && instr[5] |=> $stable(acc))
    else $error("copy back");
  a_store_keeps_state: assert property (sto |=> $stable(acc) && $stable(null_result_flag))
    else $error("store");
  a_prescale_from_acc: assert property (pre |=> prescale_cfg == $past(acc))
    else $error("prescale");
  a_prescale_held: assert property (!pre |=> $stable(prescale_cfg))
    else $error("prescale held");
  a_idle_holds: assert property (idle_instr |=> $stable({acc, null_result_flag, prescale_cfg}))
    else $error("idle");
  a_done_follows: assert property (instr_valid |=> done)
    else $error("done");
  a_done_quiet: assert property (!instr_valid |=> !done)
    else $error("done without word");
  a_other_flagged: assert property ((instr_valid && !(lit || cpy || sto || pre || idle_instr)) |=> unhandled)
    else $error("unhandled missing");
  a_group_quiet: assert property ((!instr_valid || lit || cpy || sto || pre || idle_instr) |=> !unhandled)
    else $error("unhandled raised");
  cover property (cpy && !instr[5]);
  cover property (cpy && instr[5]);
  cover property (pre);
  cover property (sto);
endmodule : mie_exec_asserts
bind mie_exec mie_exec_asserts u_chk (.clk, .rst, .instr_valid, .instr, .acc, .null_result_flag,
  .prescale_cfg, .done, .unhandled);

// File: testbench/mie_exec_tb.sv
/* Self-checking bench for mie_exec.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module mie_exec_tb;
  import mie_pkg::*;
  logic clk = 0, rst = 1, instr_valid = 0, null_result_flag, done, unhandled;
  logic [INSTR_W-1:0] instr = 12'h000;
  logic [DATA_W-1:0] acc, prescale_cfg;
  int fail_count = 0, check_count = 0;
  // Word, acc, flag, prescale
  logic [31:0] rows [13] = '{32'hC5A_5A_0_FF, 32'h02A_5A_0_FF, 32'hC00_00_0_FF, 32'h20A_5A_0_FF,
    32'h203_00_1_FF, 32'hC77_77_1_FF, 32'h002_77_1_77, 32'h000_77_1_77, 32'h03F_77_1_77,
    32'hC00_00_1_77, 32'h23F_00_0_77, 32'h21F_77_0_77, 32'h22B_77_1_77};
  always #25 clk = ~clk;
  mie_exec uut (.clk, .rst, .instr_valid, .instr, .acc, .null_result_flag, .prescale_cfg, .done,
    .unhandled);
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task step(input logic [11:0] w);
    @(negedge clk);
    instr = w;
    instr_valid = 1;
    @(posedge clk);
    #1;
    chk("done", 8'h01, {7'h00, done});
  endtask : step
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 0;
    foreach (rows[i]) begin
      step(rows[i][31:20]);
      chk("acc", rows[i][19:12], acc);
      chk("flag", {4'h0, rows[i][11:8]}, {7'h00, null_result_flag});
      chk("prescale", rows[i][7:0], prescale_cfg);
      chk("unhandled", 8'h00, {7'h00, unhandled});
      $display("row %0d done", i);
    end
    @(negedge clk) rst = 1;
    instr_valid = 0;
    @(posedge clk);
    #1;
    chk("reset prescale", 8'hFF, prescale_cfg);
    chk("reset acc", 8'h00, acc);
    chk("reset flag", 8'h00, {7'h00, null_result_flag});
    chk("reset done", 8'h00, {7'h00, done});
    @(negedge clk) rst = 0;
    instr = 12'hC33;
    @(posedge clk);
    #1;
    chk("word without valid", 8'h00, acc);
    chk("no retire", 8'h00, {7'h00, done});
    step(12'h21F);
    chk("cleared reg", 8'h00, acc);
    chk("cleared flag", 8'h01, {7'h00, null_result_flag});
    step(12'hFFF);
    chk("other word", 8'h01, {7'h00, unhandled});
    chk("other acc", 8'h00, acc);
    $display("reset and other word done");
    conclude();
  end
endmodule : mie_exec_tb
